/* logic/dpp_port.sv */
/*
  dpp_port: decimal parallel port with Avalon-MM register slave.
  Assumes peripheral inputs are synchronous to clock.
*/
`timescale 1ns/10ps
`default_nettype none
module dpp_port
#(
  parameter int          PRESET_COUNT = dpp_pkg::PRESET_CYCLES, // shortenable reset pulse
  parameter logic [7:0]  CARD_ID      = dpp_pkg::CARD_ID_DEFAULT // arbitrary value
)
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [5:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  output logic                      avs_readdatavalid,
  input  wire dpp_pkg::dpp_inputs_t periph_in,
  input  wire logic [4:0]           config_switches,
  input  wire logic                 data_flag_ready,
  output logic                      request_line_a,
  output logic                      request_line_b,
  output logic                      preset_n,
  output logic [7:0]                data_out,
  output logic                      binary_mode,
  output logic [7:0]                pointer_ff,
  output logic                      irq
);
  // ==========================================================================
  // register map, word index = avs_address[5:2]; data in [7:0], upper bits zero
  //   0    read: identification          write nonzero: interface reset
  //   1    read: enable(7), request(6)   write nonzero: clear transfer pointer
  //   2    read: busy(0)                 write nonzero: start a handshake
  //   3    read: binary mode(0)          write: nonzero binary, zero decimal
  //   4    read: switches(7:3), sign one, sign two, overload
  //        write: output lines
  //   5..9 read: digit pairs, odd digit high nibble, even digit low nibble
  //   A    enable and mask; nonzero enables one ready interrupt
  //   B    sticky ready status, write one to clear
  //   other indexes read zero and ignore writes
  //
  // bus timing: a request is answered at the second edge after it rises;
  // the first edge registers read data and lowers waitrequest, the second
  // edge is where a write lands and the master takes read data. requests
  // may follow back to back, one transfer every two cycles.
  // ==========================================================================
  // declarations
  dpp_pkg::dpp_state_t  state_ff;      // handshake controller state
  dpp_pkg::dpp_state_t  nxt_state;
  logic                 ack_ff;        // bus answer phase
  logic                 wr_ev;         // a write is accepted this cycle
  logic [3:0]           idx;           // word index
  logic                 nz;            // nonzero write data
  logic                 irq_req_ff;    // pending ready request
  logic                 irq_en_ff;     // interrupt enable
  logic                 sts_ff;        // sticky ready status
  logic                 msk_ff;        // status mask
  logic [7:0]           out_latch_ff;  // value written to output register
  logic [31:0]          pre_cnt_ff;    // preset pulse counter
  dpp_pkg::dpp_inputs_t in_ff;         // latched peripheral inputs
  logic                 done;          // handshake completes
  logic                 if_reset;      // software interface reset
  logic [7:0]           rd_byte;       // read mux result

  assign idx      = avs_address[5:2];
  assign wr_ev    = avs_write && ack_ff;
  assign nz       = |avs_writedata[7:0];
  assign if_reset = wr_ev && (idx == dpp_pkg::IDX_ID_RESET) && nz;
  // the peripheral releases its flag path only once request lines drop
  assign done     = (state_ff == dpp_pkg::HS_WAIT) && data_flag_ready;

  // ==========================================================================
  // bus slave: one wait cycle, then the answer edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read || avs_write) && !ack_ff;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
  end

  // read multiplexer
  always_comb
  begin
    case (idx)
      dpp_pkg::IDX_ID_RESET:   rd_byte = CARD_ID;
      dpp_pkg::IDX_IRQ_PTR:    rd_byte = {irq_en_ff, irq_req_ff, 6'h00};
      dpp_pkg::IDX_BUSY_REQ:   rd_byte = {7'h00, state_ff == dpp_pkg::HS_WAIT};
      dpp_pkg::IDX_MODE:       rd_byte = {7'h00, binary_mode};
      dpp_pkg::IDX_LINES_OUT:  rd_byte = {config_switches, in_ff.sign_one,
                                          in_ff.sign_two, in_ff.overload};
      dpp_pkg::IDX_DIG_1_2:    rd_byte = in_ff.digits[39:32];
      dpp_pkg::IDX_DIG_3_4:    rd_byte = in_ff.digits[31:24];
      dpp_pkg::IDX_DIG_5_6:    rd_byte = in_ff.digits[23:16];
      dpp_pkg::IDX_DIG_7_8:    rd_byte = in_ff.digits[15:8];
      dpp_pkg::IDX_DIG_9_10:   rd_byte = in_ff.digits[7:0];
      dpp_pkg::IDX_IRQ_ENABLE: rd_byte = {7'h00, msk_ff};
      dpp_pkg::IDX_IRQ_STATUS: rd_byte = {7'h00, sts_ff};
      default:                 rd_byte = 8'h00; // unmapped reads zero
    endcase
  end

  // read data registered at the first edge, one edge before the answer edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata <= 32'h0000_0000;
    else if ((avs_read || avs_write) && !ack_ff)
      avs_readdata <= {24'h00_0000, rd_byte};
  end

  // readdatavalid pulses with the answer edge; masters that rely on
  // waitrequest alone may leave it unconnected
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdatavalid <= 1'b0;
    else
      avs_readdatavalid <= avs_read && !ack_ff;
  end

  // ==========================================================================
  // handshake controller
  //   idle  -> a nonzero write to index 2 raises both request lines
  //   wait  -> the peripheral answers with its ready flag; on that edge the
  //            inputs are latched, the output byte is presented again, the
  //            request flag and sticky status are set and the pointer counts
  //   reset -> preset held low for PRESET_COUNT cycles, request lines low
  // a request written during wait or reset is not queued; it only clears
  // the pending interrupt request, so software should poll busy first
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      dpp_pkg::HS_IDLE:
        if (wr_ev && idx == dpp_pkg::IDX_BUSY_REQ && nz)
          nxt_state = dpp_pkg::HS_WAIT;
      dpp_pkg::HS_WAIT:
        if (done)
          nxt_state = dpp_pkg::HS_IDLE;
      dpp_pkg::HS_RESET:
        if (pre_cnt_ff == 32'(PRESET_COUNT - 1))
          nxt_state = dpp_pkg::HS_IDLE;
      default:
        nxt_state = dpp_pkg::HS_IDLE;
    endcase
    if (if_reset)
      nxt_state = dpp_pkg::HS_RESET;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= dpp_pkg::HS_IDLE;
    else
      state_ff <= nxt_state;
  end

  // preset pulse length counter
  // wide enough for any PRESET_COUNT; only the compare against
  // PRESET_COUNT - 1 ends the pulse
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_ff <= 32'h0000_0000;
    else if (state_ff != dpp_pkg::HS_RESET || if_reset)
      pre_cnt_ff <= 32'h0000_0000;
    else
      pre_cnt_ff <= pre_cnt_ff + 32'h0000_0001;
  end

  // request lines and preset follow the state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      request_line_a <= 1'b0;
      request_line_b <= 1'b0;
      preset_n       <= 1'b1;
    end
    else
    begin
      request_line_a <= (nxt_state == dpp_pkg::HS_WAIT);
      request_line_b <= (nxt_state == dpp_pkg::HS_WAIT);
      preset_n       <= (nxt_state != dpp_pkg::HS_RESET);
    end
  end

  // ==========================================================================
  // output latch and output lines; inputs latched each handshake
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      out_latch_ff <= dpp_pkg::OUT_RESET;
    else if (if_reset)
      out_latch_ff <= dpp_pkg::OUT_RESET;
    else if (wr_ev && idx == dpp_pkg::IDX_LINES_OUT)
      out_latch_ff <= avs_writedata[7:0];
  end

  // a write shows on the lines at once; completion presents the latched
  // byte again so the peripheral sees it under handshake control
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      data_out <= dpp_pkg::OUT_RESET;
    else if (if_reset)
      data_out <= dpp_pkg::OUT_RESET;
    else if (wr_ev && idx == dpp_pkg::IDX_LINES_OUT)
      data_out <= avs_writedata[7:0];
    else if (done)
      data_out <= out_latch_ff;
  end

  // inputs are latched only on completion, so status reads between
  // handshakes stay steady while the peripheral lines move
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      in_ff <= '0;
    else if (done)
      in_ff <= periph_in;
  end

  // ==========================================================================
  // mode and pointer
  // mode falls back to decimal on an interface reset
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      binary_mode <= 1'b0;
    else if (if_reset)
      binary_mode <= 1'b0;
    else if (wr_ev && idx == dpp_pkg::IDX_MODE)
      binary_mode <= nz;
  end

  // transfer pointer counts completed handshakes
  // it wraps after 256 handshakes; it only helps software count bytes,
  // nothing else in the port depends on it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pointer_ff <= 8'h00;
    else if (if_reset || (wr_ev && idx == dpp_pkg::IDX_IRQ_PTR && nz))
      pointer_ff <= 8'h00;
    else if (done)
      pointer_ff <= pointer_ff + 8'h01;
  end

  // ==========================================================================
  // interrupt request, enable, sticky status and mask
  // the request flag is the only cause, so no cause register exists.
  // the enable drops on the first edge that sees request and enable
  // together, which leaves irq high for one cycle per enable; software
  // writes index A again before the next ready can interrupt.
  // a ready that lands in the same cycle as a clearing write wins.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_req_ff <= 1'b0;
    else if (done)
      irq_req_ff <= 1'b1;
    else if (if_reset || (wr_ev && idx == dpp_pkg::IDX_BUSY_REQ && nz))
      irq_req_ff <= 1'b0;
  end

  // enable drops once a request is taken, software must re-enable
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_en_ff <= 1'b0;
    else if (wr_ev && idx == dpp_pkg::IDX_IRQ_ENABLE)
      irq_en_ff <= nz;
    else if (if_reset || (irq_en_ff && irq_req_ff))
      irq_en_ff <= 1'b0;
  end

  // mask copy of the enable write, kept for the status and mask layout
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      msk_ff <= 1'b0;
    else if (wr_ev && idx == dpp_pkg::IDX_IRQ_ENABLE)
      msk_ff <= nz;
  end

  // sticky status: set wins over write-one-clear
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      sts_ff <= 1'b0;
    else if (done)
      sts_ff <= 1'b1;
    else if (wr_ev && idx == dpp_pkg::IDX_IRQ_STATUS && avs_writedata[0])
      sts_ff <= 1'b0;
  end

  // interrupt output: request held and enabled
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= irq_req_ff && irq_en_ff && msk_ff;
  end
endmodule
`default_nettype wire

/* logic/dpp_pkg.sv */
/*
  dpp_pkg: constants and carrier types for the decimal parallel port.
  Assumes a 100 MHz clock and a 32-bit Avalon-MM register slave.
*/
`default_nettype none
package dpp_pkg;
  // ==========================================================================
  // register word indices (byte address = index * 4)
  localparam logic [3:0] IDX_ID_RESET   = 4'h0; // id read / interface reset write
  localparam logic [3:0] IDX_IRQ_PTR    = 4'h1; // interrupt state read / pointer reset write
  localparam logic [3:0] IDX_BUSY_REQ   = 4'h2; // busy read / handshake request write
  localparam logic [3:0] IDX_MODE       = 4'h3; // number mode
  localparam logic [3:0] IDX_LINES_OUT  = 4'h4; // switch+line state read / output lines write
  localparam logic [3:0] IDX_DIG_1_2    = 4'h5; // digits 1 and 2
  localparam logic [3:0] IDX_DIG_3_4    = 4'h6; // digits 3 and 4
  localparam logic [3:0] IDX_DIG_5_6    = 4'h7; // digits 5 and 6
  localparam logic [3:0] IDX_DIG_7_8    = 4'h8; // digits 7 and 8
  localparam logic [3:0] IDX_DIG_9_10   = 4'h9; // digits 9 and 10
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'hA; // interrupt enable mask
  localparam logic [3:0] IDX_IRQ_STATUS = 4'hB; // sticky status, write one to clear
  // ==========================================================================
  // field positions
  localparam int IRQ_EN_BIT   = 7; // interrupts enabled in interrupt state
  localparam int IRQ_REQ_BIT  = 6; // interrupt request in interrupt state
  localparam int BUSY_BIT     = 0; // handshake in progress
  // ==========================================================================
  // reset values and identity
  localparam logic [7:0] CARD_ID_DEFAULT = 8'h2A; // arbitrary identification value
  localparam logic [7:0] OUT_RESET       = 8'h00;
  // ==========================================================================
  // timing
  localparam int CLK_MHZ        = 100;
  localparam int PRESET_US      = 15;
  localparam int PRESET_CYCLES  = PRESET_US * CLK_MHZ; // least time, exact
  // ==========================================================================
  // inputs sampled from the peripheral
  typedef struct packed {
    logic [39:0] digits;   // digit 1 in [39:36] ... digit 10 in [3:0]
    logic        sign_one;
    logic        sign_two;
    logic        overload;
  } dpp_inputs_t;
  // handshake states
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b001,
    HS_WAIT  = 3'b010,
    HS_RESET = 3'b100
  } dpp_state_t;
endpackage
`default_nettype wire

/* testbench/dpp_port_props.sv */
/* dpp_port_props: port checker for dpp_port.
   Assumes it is bound into dpp_port; one clock domain. */
`timescale 1ns/10ps
`default_nettype none
module dpp_port_props
#(
  parameter int         PRESET_COUNT = 4,
  parameter logic [7:0] CARD_ID      = dpp_pkg::CARD_ID_DEFAULT
)
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        data_flag_ready,
  input wire logic        request_line_a,
  input wire logic        request_line_b,
  input wire logic        preset_n,
  input wire logic [7:0]  data_out,
  input wire logic        binary_mode,
  input wire logic        irq
);
  // ==========================================
  // helpers
  logic       acc_w;      // write taken at this edge
  logic [3:0] idx;        // word index
  int         low_cnt_ff; // cycles preset held low
  assign acc_w = avs_write && !avs_waitrequest;
  assign idx   = avs_address[5:2];
  // count the length of the preset pulse
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      low_cnt_ff <= 0;
    else
      low_cnt_ff <= preset_n ? 0 : low_cnt_ff + 1;
  // ==========================================
  // assertions
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_REQ_PAIR:
    assert property (request_line_a == request_line_b) else $error("request lines differ");
  AST_REQ_SET:
    assert property (acc_w && idx == 4'h2 && avs_writedata[7:0] != 8'h00 |=> request_line_a)
    else $error("request not raised");
  AST_REQ_DONE:
    assert property (request_line_a && data_flag_ready |=> !request_line_a) else $error("request not dropped");
  AST_CARD_ID:
    assert property (avs_read && !avs_waitrequest && idx == 4'h0 |-> avs_readdata == {24'h0, CARD_ID})
    else $error("bad card id");
  AST_IRQ_ONCE:
    assert property ($rose(irq) |=> ##[0:2] !irq) else $error("interrupt not disabled");
  AST_PRESET_GO:
    assert property (acc_w && idx == 4'h0 && avs_writedata[7:0] != 8'h00 |=> !preset_n)
    else $error("reset not started");
  AST_PRESET_LEN:
    assert property ($rose(preset_n) |-> low_cnt_ff >= PRESET_COUNT) else $error("preset pulse short");
  AST_PRESET_CLR:
    assert property ($rose(preset_n) |-> !request_line_a && data_out == 8'h00) else $error("lines not cleared");
  AST_MODE:
    assert property (acc_w && idx == 4'h3 |=> binary_mode == ($past(avs_writedata[7:0]) != 8'h00))
    else $error("bad mode");
  AST_DOUT:
    assert property (acc_w && idx == 4'h4 |=> data_out == $past(avs_writedata[7:0])) else $error("bad data out");
endmodule
bind dpp_port dpp_port_props #(.PRESET_COUNT(PRESET_COUNT), .CARD_ID(CARD_ID)) u_props
  (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
   .data_flag_ready, .request_line_a, .request_line_b, .preset_n, .data_out, .binary_mode, .irq);
`default_nettype wire

/* testbench/dpp_periph_model.sv */
/* dpp_periph_model: instrument on the far side of the port.
   Assumes request lines come from dpp_port; answers after delay. */
`timescale 1ns/10ps
`default_nettype none
module dpp_periph_model
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 request_line_a,
  input  wire logic                 request_line_b,
  input  wire logic [3:0]           delay,
  input  wire dpp_pkg::dpp_inputs_t value,
  output logic                      data_flag_ready,
  output dpp_pkg::dpp_inputs_t      periph_in
);
  logic [3:0] wait_ff; // cycles since request seen
  // ==========================================
  // raise ready after delay, drop it once request clears
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_ff         <= 4'h0;
      data_flag_ready <= 1'b0;
    end
    else if (request_line_a && request_line_b && !data_flag_ready)
    begin
      wait_ff <= wait_ff + 4'h1;
      if (wait_ff == delay)
        data_flag_ready <= 1'b1;
    end
    else if (!request_line_a)
    begin
      wait_ff         <= 4'h0;
      data_flag_ready <= 1'b0;
    end
  end
  // data only valid while ready; otherwise a changed pattern
  assign periph_in = data_flag_ready ? value : ~value;
endmodule
`default_nettype wire

/* testbench/test_dpp_port.sv */
/* test_dpp_port: self-checking bench for dpp_port.
   Assumes the periph model and bound checker are compiled. */
`timescale 1ns/10ps
`default_nettype none
module test_dpp_port;
  logic clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, data_flag_ready, request_line_a, request_line_b, preset_n, binary_mode, irq;
  logic [4:0] config_switches = 5'h00;
  logic [3:0] dly = 4'h6;
  logic [7:0] data_out, pointer_ff, r;
  logic [7:0] exp_out = 8'h00;
  dpp_pkg::dpp_inputs_t pv = '0, periph_in;
  int errors = 0, n_tests = 0, irq_cnt = 0, base;
  always #5 clock = ~clock;
  always @(posedge clock) if (irq === 1'b1) irq_cnt++;
  dpp_port #(.PRESET_COUNT(4)) u_dut (.clock, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .avs_readdatavalid(), .periph_in, .config_switches,
    .data_flag_ready, .request_line_a, .request_line_b, .preset_n, .data_out, .binary_mode, .pointer_ff, .irq);
  dpp_periph_model u_peer (.clock, .rst_n, .request_line_a, .request_line_b, .delay(dly), .value(pv),
    .data_flag_ready, .periph_in);
  // ==========================================
  // tasks and expectations
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    if (n == 50) errors++;
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [7:0] pair(input dpp_pkg::dpp_inputs_t v, input int k);
    return v.digits[39 - 8 * k -: 8];
  endfunction
  // one full handshake with fresh random inputs
  task automatic hs;
    int n;
    n = 0;
    exp_out = 8'($urandom);
    bus(1'b1, 4'h4, exp_out, r);
    pv  <= 43'({$urandom, $urandom});
    dly <= 4'h6 + 4'($urandom % 8);
    config_switches <= 5'($urandom);
    bus(1'b1, 4'h2, 8'($urandom % 255 + 1), r);
    bus(1'b0, 4'h2, 8'h00, r); chk(r[0], 1'b1);
    while (request_line_a !== 1'b0 && n < 100)
    begin
      @(posedge clock);
      n++;
    end
    bus(1'b0, 4'h2, 8'h00, r); chk(r[0], 1'b0);
    bus(1'b0, 4'h1, 8'h00, r); chk(r[6], 1'b1);
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b0, 4'(5 + k), 8'h00, r); chk(r, pair(pv, k));
    end
    bus(1'b0, 4'h4, 8'h00, r); chk(r, {config_switches, pv.sign_one, pv.sign_two, pv.overload});
    chk(data_out, exp_out);
  endtask
  task summarize;
    $display("tests=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    summarize;
  end
  // ==========================================
  // main sequence
  initial
  begin
    void'($urandom(32'hc6e9));
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, 4'h0, 8'h00, r); chk(r, dpp_pkg::CARD_ID_DEFAULT);
    bus(1'b0, 4'hC, 8'h00, r); chk(r, 8'h00);
    $display("test id done");
    for (int i = 1; i >= 0; i--)
    begin
      base = i ? 0 : $urandom % 255 + 1;
      bus(1'b1, 4'h3, 8'(base), r);
      bus(1'b0, 4'h3, 8'h00, r); chk(r, {7'h0, base != 0});
      chk(binary_mode, base != 0);
    end
    base = $urandom % 256;
    bus(1'b1, 4'h4, 8'(base), r); chk(data_out, 8'(base));
    $display("test mode done");
    bus(1'b1, 4'hA, 8'h00, r);
    base = irq_cnt;
    repeat (3) hs;
    bus(1'b1, 4'h5, 8'hFF, r);
    bus(1'b0, 4'h5, 8'h00, r); chk(r, pair(pv, 0));
    chk(irq_cnt, base);
    bus(1'b1, 4'h2, 8'h01, r);
    bus(1'b1, 4'hA, 8'h40, r);
    repeat (40) @(posedge clock);
    hs;
    chk(irq_cnt > base, 1'b1);
    bus(1'b0, 4'h1, 8'h00, r); chk(r[7], 1'b0);
    bus(1'b0, 4'hB, 8'h00, r); chk(r[0], 1'b1);
    bus(1'b1, 4'hB, 8'h01, r);
    bus(1'b0, 4'hB, 8'h00, r); chk(r[0], 1'b0);
    dly <= 4'hF;
    bus(1'b1, 4'h2, 8'h01, r);
    bus(1'b0, 4'h1, 8'h00, r); chk(r[6], 1'b0);
    $display("test irq done");
    bus(1'b1, 4'h1, 8'h01, r); chk(pointer_ff, 8'h00);
    bus(1'b1, 4'h3, 8'h01, r);
    bus(1'b1, 4'h2, 8'h01, r);
    bus(1'b1, 4'h0, 8'h01, r);
    repeat (8) @(posedge clock);
    chk({preset_n, request_line_a, binary_mode, data_out}, 11'h400);
    $display("test reset done");
    summarize;
  end
endmodule
`default_nettype wire
